// *** design/err_capture_pkg.sv ***
// Package with register map, field layout and reset values of the error capture block
package err_capture_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_UPPER_OFFSET = 12'h270;
  localparam logic [11:0] ADDR_LOWER_OFFSET = 12'h274;
  localparam logic [11:0] ATTR_PHASE_OFFSET = 12'h278;
  localparam logic [11:0] SPLIT_MSG_OFFSET = 12'h27C;
  localparam logic [11:0] ATTR_CAPTURE_OFFSET = 12'h280;
  localparam logic [11:0] CONTROL_OFFSET = 12'h284;

  // ----------------------------------------------------------------
  // Attribute capture register fields
  // ----------------------------------------------------------------
  localparam int VALID_BIT = 31;
  localparam int OVERFLOW_BIT = 30;
  localparam int CLEAR_BIT = 29;
  localparam int CAUSE_LSB = 8;
  localparam int CAUSE_WIDTH = 10;
  localparam int BE_LSB = 4;
  localparam int CMD_LSB = 0;

  // Cause vector bit positions, relative to CAUSE_LSB
  localparam int CAUSE_DELAYED_TIMEOUT = 0;
  localparam int CAUSE_TARGET_ABORT = 1;
  localparam int CAUSE_MASTER_ABORT = 2;
  localparam int CAUSE_RETRY_LIMIT = 3;
  localparam int CAUSE_DETECTED_PARITY = 4;
  localparam int CAUSE_MASTER_PARITY = 5;
  localparam int CAUSE_SPLIT_ERR_MSG = 6;
  localparam int CAUSE_SPLIT_TIMEOUT = 7;
  localparam int CAUSE_UNEXPECTED_SPLIT = 8;
  localparam int CAUSE_SPLIT_DROPPED = 9;

  // Control register: parity-error-response enable
  localparam int PARITY_RESPONSE_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and response codes
  // ----------------------------------------------------------------
  localparam logic [31:0] CAPTURE_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** design/err_capture_core.sv ***
// Capture core: records one error event and freezes until cleared
`timescale 1ns/1ps

module err_capture_core
  import err_capture_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic event_valid,
  input wire logic [err_capture_pkg::CAUSE_WIDTH-1:0] event_causes,
  input wire logic [63:0] event_address,
  input wire logic [3:0] event_command,
  input wire logic [3:0] event_byte_enables,
  input wire logic [31:0] event_attr_word,
  input wire logic [31:0] event_split_msg,
  input wire logic clear_pulse,
  output logic [31:0] addr_upper_q,
  output logic [31:0] addr_lower_q,
  output logic [31:0] attr_phase_q,
  output logic [31:0] split_msg_q,
  output logic [err_capture_pkg::CAUSE_WIDTH-1:0] causes_q,
  output logic [3:0] command_q,
  output logic [3:0] byte_enables_q,
  output logic valid_q,
  output logic overflow_q
);

  logic load;

  // Capture only while not frozen
  assign load = event_valid && !valid_q;

  // ----------------------------------------------------------------
  // Status and overflow
  // ----------------------------------------------------------------
  // Clear wins here over a same-cycle event: clear zeroes the whole record
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_q <= 1'b0;
      overflow_q <= 1'b0;
    end else if (clear_pulse) begin
      valid_q <= 1'b0;
      overflow_q <= 1'b0;
    end else if (load) begin
      valid_q <= 1'b1;
    end else if (event_valid) begin
      overflow_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Captured record
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_upper_q <= CAPTURE_RESET;
      addr_lower_q <= CAPTURE_RESET;
      attr_phase_q <= CAPTURE_RESET;
      split_msg_q <= CAPTURE_RESET;
      causes_q <= '0;
      command_q <= 4'h0;
      byte_enables_q <= 4'h0;
    end else if (clear_pulse) begin
      addr_upper_q <= CAPTURE_RESET;
      addr_lower_q <= CAPTURE_RESET;
      attr_phase_q <= CAPTURE_RESET;
      split_msg_q <= CAPTURE_RESET;
      causes_q <= '0;
      command_q <= 4'h0;
      byte_enables_q <= 4'h0;
    end else if (load) begin
      addr_upper_q <= event_address[63:32];
      addr_lower_q <= event_address[31:0];
      attr_phase_q <= event_attr_word;
      split_msg_q <= event_split_msg;
      causes_q <= event_causes;
      command_q <= event_command;
      byte_enables_q <= event_byte_enables;
    end
  end

endmodule

// *** design/pci_error_capture.sv ***
// Top level: error capture record behind an AXI4-Lite register slave
`timescale 1ns/1ps

module pci_error_capture
  import err_capture_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  // Error event inputs from the PCI side logic, same clock
  input wire logic split_completion_dropped,
  input wire logic unexpected_split,
  input wire logic split_response_timeout,
  input wire logic split_error_message,
  input wire logic parity_error_seen,
  input wire logic is_bus_master,
  input wire logic master_read_parity_error,
  input wire logic target_write_parity_error,
  input wire logic retry_limit_exceeded,
  input wire logic master_abort,
  input wire logic target_abort,
  input wire logic delayed_txn_timeout,
  input wire logic other_bus_error,
  input wire logic [63:0] error_address,
  input wire logic [3:0] error_command,
  input wire logic [3:0] attribute_byte_enables,
  input wire logic [31:0] error_attribute_phase_word,
  input wire logic [31:0] error_split_message,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Parity-error-response enable as seen by the PCI logic
  output logic parity_response_en
);

  import err_capture_pkg::*;

  // ----------------------------------------------------------------
  // Cause encoding
  // ----------------------------------------------------------------
  logic [CAUSE_WIDTH-1:0] causes;
  logic event_valid;
  logic [31:0] command_register_q;

  always_comb begin
    causes = '0;
    causes[CAUSE_SPLIT_DROPPED] = split_completion_dropped;
    causes[CAUSE_UNEXPECTED_SPLIT] = unexpected_split;
    causes[CAUSE_SPLIT_TIMEOUT] = split_response_timeout;
    causes[CAUSE_SPLIT_ERR_MSG] = split_error_message;
    causes[CAUSE_MASTER_PARITY] = parity_error_seen && is_bus_master
      && command_register_q[PARITY_RESPONSE_BIT];
    causes[CAUSE_DETECTED_PARITY] = (master_read_parity_error && is_bus_master)
      || (target_write_parity_error && !is_bus_master);
    causes[CAUSE_RETRY_LIMIT] = retry_limit_exceeded;
    causes[CAUSE_MASTER_ABORT] = master_abort;
    causes[CAUSE_TARGET_ABORT] = target_abort;
    causes[CAUSE_DELAYED_TIMEOUT] = delayed_txn_timeout;
  end

  // Any cause, or a bus error with no listed cause, is an error event
  assign event_valid = (|causes) || other_bus_error || parity_error_seen;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic write_fire;
  logic clear_pulse;

  assign write_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  // Address and data taken in either order, one write at a time
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (write_fire) begin
      aw_held_q <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (write_fire) begin
      w_held_q <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_bvalid;
    end
  end

  function automatic logic is_mapped(input logic [11:0] addr);
    case ({addr[11:2], 2'b00})
      ADDR_UPPER_OFFSET, ADDR_LOWER_OFFSET, ATTR_PHASE_OFFSET,
      SPLIT_MSG_OFFSET, ATTR_CAPTURE_OFFSET, CONTROL_OFFSET: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // Only a one in the clear bit acts; a zero has no effect
  assign clear_pulse = write_fire && ({aw_addr_q[11:2], 2'b00} == ATTR_CAPTURE_OFFSET)
    && w_strb_q[3] && w_data_q[CLEAR_BIT];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      command_register_q <= CONTROL_RESET;
    end else if (write_fire && ({aw_addr_q[11:2], 2'b00} == CONTROL_OFFSET) && w_strb_q[0]) begin
      command_register_q[PARITY_RESPONSE_BIT] <= w_data_q[PARITY_RESPONSE_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      parity_response_en <= 1'b0;
    end else begin
      parity_response_en <= command_register_q[PARITY_RESPONSE_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (write_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Capture core
  // ----------------------------------------------------------------
  logic [31:0] addr_upper;
  logic [31:0] addr_lower;
  logic [31:0] attr_phase;
  logic [31:0] split_msg;
  logic [CAUSE_WIDTH-1:0] causes_cap;
  logic [3:0] command_cap;
  logic [3:0] byte_enables_cap;
  logic valid_cap;
  logic overflow_cap;

  err_capture_core u_core (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .event_valid(event_valid),
    .event_causes(causes),
    .event_address(error_address),
    .event_command(error_command),
    .event_byte_enables(attribute_byte_enables),
    .event_attr_word(error_attribute_phase_word),
    .event_split_msg(error_split_message),
    .clear_pulse(clear_pulse),
    .addr_upper_q(addr_upper),
    .addr_lower_q(addr_lower),
    .attr_phase_q(attr_phase),
    .split_msg_q(split_msg),
    .causes_q(causes_cap),
    .command_q(command_cap),
    .byte_enables_q(byte_enables_cap),
    .valid_q(valid_cap),
    .overflow_q(overflow_cap)
  );

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [31:0] attr_word;

  // Clear bit and reserved bits always read zero
  always_comb begin
    attr_word = 32'h0000_0000;
    attr_word[VALID_BIT] = valid_cap;
    attr_word[OVERFLOW_BIT] = overflow_cap;
    attr_word[CAUSE_LSB +: CAUSE_WIDTH] = causes_cap;
    attr_word[BE_LSB +: 4] = byte_enables_cap;
    attr_word[CMD_LSB +: 4] = command_cap;
  end

  function automatic logic [31:0] read_mux(input logic [11:0] addr);
    case ({addr[11:2], 2'b00})
      ADDR_UPPER_OFFSET: read_mux = addr_upper;
      ADDR_LOWER_OFFSET: read_mux = addr_lower;
      ATTR_PHASE_OFFSET: read_mux = attr_phase;
      SPLIT_MSG_OFFSET: read_mux = split_msg;
      ATTR_CAPTURE_OFFSET: read_mux = attr_word;
      CONTROL_OFFSET: read_mux = command_register_q;
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_mux(s_axi_araddr);
      s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// *** verif/pci_agent_model.sv ***
// Bus agent model that raises one error event at a time
`timescale 1ns/1ps
module pci_agent_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [3:0] kind,
  input wire logic master,
  input wire logic [135:0] rec,
  output logic [11:0] pulse = 12'h000,
  output logic bus_master = 1'b0,
  output logic [135:0] rec_out = '0
);
  // Idle record lines toggle so a stale value is never mistaken for a capture
  always @(posedge sys_clk) begin
    bus_master <= master;
    if (go) begin
      pulse <= 12'h001 << kind;
      rec_out <= rec;
    end else begin
      pulse <= 12'h000;
      rec_out <= ~rec_out;
    end
  end
endmodule

// *** verif/pci_error_capture_asserts.sv ***
// Checker for register handshake and captured record relations
`timescale 1ns/1ps
module pci_error_capture_asserts
  import err_capture_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic parity_response_en
);
  logic [11:0] rd_addr_q;
  logic attr_rd;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_addr_q <= 12'h000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_q <= s_axi_araddr;
    end
  end
  assign attr_rd = s_axi_rvalid && rd_addr_q == ATTR_CAPTURE_OFFSET;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_W_REFUSED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_PARITY_LAG: assert property ($changed(parity_response_en) |-> $past(s_axi_bvalid))
    else $error("parity enable moved without a write");
  AST_CLEAR_READS_ZERO: assert property (attr_rd |-> s_axi_rdata[CLEAR_BIT:18] == 12'h000)
    else $error("clear or reserved bits read nonzero");
  AST_OVERFLOW_NEEDS_VALID: assert property (attr_rd && s_axi_rdata[OVERFLOW_BIT] |-> s_axi_rdata[VALID_BIT])
    else $error("overflow without status");
  AST_RECORD_NEEDS_VALID: assert property (attr_rd && s_axi_rdata[17:0] != 18'h0 |-> s_axi_rdata[VALID_BIT])
    else $error("record fields without status");
endmodule
bind pci_error_capture pci_error_capture_asserts pci_error_capture_asserts_i (.sys_clk, .reset_n, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .parity_response_en);

// *** verif/test_pci_error_capture.sv ***
// Testbench for the error capture register block
`timescale 1ns/1ps
module test_pci_error_capture;
  import err_capture_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic go = 1'b0;
  logic [3:0] kind = 4'h0;
  logic master = 1'b0;
  logic [135:0] rec = '0;
  logic [11:0] pulse;
  logic bus_master;
  logic [135:0] rec_out;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rdata_seen;
  logic [1:0] resp_seen;
  logic par_en;
  integer seed = 32'h79F4;
  int fails = 0;
  int total_checks = 0;
  int cause_pos[12] = '{CAUSE_SPLIT_DROPPED, CAUSE_UNEXPECTED_SPLIT, CAUSE_SPLIT_TIMEOUT, CAUSE_SPLIT_ERR_MSG,
    CAUSE_MASTER_PARITY, CAUSE_DETECTED_PARITY, CAUSE_DETECTED_PARITY, CAUSE_RETRY_LIMIT, CAUSE_MASTER_ABORT,
    CAUSE_TARGET_ABORT, CAUSE_DELAYED_TIMEOUT, 0};
  logic [11:0] offs[5] = '{ADDR_UPPER_OFFSET, ADDR_LOWER_OFFSET, ATTR_PHASE_OFFSET, SPLIT_MSG_OFFSET,
    ATTR_CAPTURE_OFFSET};
  logic [31:0] exp_regs[5];
  logic m;
  logic pen;
  logic [135:0] r;

  always #25 sys_clk = ~sys_clk;

  pci_agent_model pci_agent_model_i (.sys_clk, .go, .kind, .master, .rec, .pulse, .bus_master, .rec_out);

  pci_error_capture pci_error_capture_i (.sys_clk, .reset_n, .split_completion_dropped(pulse[0]),
    .unexpected_split(pulse[1]), .split_response_timeout(pulse[2]), .split_error_message(pulse[3]),
    .parity_error_seen(pulse[4]), .master_read_parity_error(pulse[5]), .target_write_parity_error(pulse[6]),
    .retry_limit_exceeded(pulse[7]), .master_abort(pulse[8]), .target_abort(pulse[9]),
    .delayed_txn_timeout(pulse[10]), .other_bus_error(pulse[11]), .is_bus_master(bus_master),
    .error_address(rec_out[135:72]), .error_attribute_phase_word(rec_out[71:40]),
    .error_split_message(rec_out[39:8]), .attribute_byte_enables(rec_out[7:4]), .error_command(rec_out[3:0]),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .parity_response_en(par_en));

  // ----------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      aw_ok = aw_ok || s_axi_awready;
      w_ok = w_ok || s_axi_wready;
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    s_axi_bready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_bvalid);
    resp_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdata_seen = s_axi_rdata;
    resp_seen = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic check_all;
    for (int j = 0; j < 5; j++) begin
      axi_read(offs[j]);
      check(rdata_seen, exp_regs[j]);
    end
  endtask

  // Master level forced for kinds 5 and 6 only; kind 4, a master-only cause, gets a random master level
  task automatic fire(input int k);
    m = (k == 5) ? 1'b1 : (k == 6) ? 1'b0 : 1'($random(seed));
    r = {$random(seed), $random(seed), $random(seed), $random(seed), 8'($random(seed))};
    @(posedge sys_clk);
    go <= 1'b1;
    kind <= 4'(k);
    master <= m;
    rec <= r;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  function automatic logic [9:0] exp_causes(input int k, input logic mst, input logic p);
    logic hit;
    hit = k != 11 && !(k == 4 && !(mst && p)) && !(k == 5 && !mst) && !(k == 6 && mst);
    return hit ? 10'h001 << cause_pos[k] : 10'h000;
  endfunction

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    exp_regs = '{default: 32'h0};
    do_reset();
    check_all();
    axi_read(12'h290);
    check({30'h0, resp_seen}, {30'h0, RESP_SLVERR});
    axi_write(12'h290, 32'h0000_0001);
    check({30'h0, resp_seen}, {30'h0, RESP_SLVERR});
    axi_write(CONTROL_OFFSET, 32'h0000_0001);
    check({30'h0, resp_seen}, {30'h0, RESP_OKAY});
    axi_read(CONTROL_OFFSET);
    check(rdata_seen, 32'h0000_0001);
    check({31'h0, par_en}, 32'h0000_0001);
    for (int i = 0; i < 24; i++) begin
      pen = 1'($random(seed));
      axi_write(CONTROL_OFFSET, {31'h0, pen});
      fire(i % 12);
      exp_regs = '{r[135:104], r[103:72], r[71:40], r[39:8], {3'b100, 11'h000, exp_causes(i % 12, m, pen), r[7:0]}};
      check_all();
      check({31'h0, par_en}, {31'h0, pen});
      fire(11 - i % 12);
      exp_regs[4][OVERFLOW_BIT] = 1'b1;
      check_all();
      axi_write(ATTR_CAPTURE_OFFSET, 32'hDFFF_FFFF);
      check_all();
      axi_write(ATTR_CAPTURE_OFFSET, 32'h2000_0000);
      exp_regs = '{default: 32'h0};
      check_all();
      $display("capture round %0d done", i);
    end
    fire(8);
    do_reset();
    check_all();
    $display("reset round done");
    stop_test();
  end

  initial begin
    #1_000_000;
    fails++;
    stop_test();
  end
endmodule
